// File: hw/e3rx_top.sv
`include "e3rx_map.svh"

module e3rx_top
  import e3rx_pkg::*;
#(
  parameter int ONE_SECOND_CYCLES = `E3RX_ONE_SECOND_CYC
) (
  input  wire logic  CLK_I,
  input  wire logic  RST_B_I,
  input  wire logic  RX_RECOVERED_LINE_CLOCK_I,
  input  wire logic  RX_RAIL_POSITIVE_I,
  input  wire logic  RX_RAIL_NEGATIVE_I,
  input  wire logic  [7:0] ADDR_I,
  input  wire logic  [7:0] WR_DATA_I,
  input  wire logic  WR_STROBE_I,
  input  wire logic  RD_STROBE_I,
  output e3rx_byte_t RD_DATA_O,
  output logic       RX_PAYLOAD_DATA_O,
  output logic       RX_PAYLOAD_VALID_O,
  output logic       RX_OVERHEAD_DATA_O,
  output logic       RX_OVERHEAD_VALID_O,
  output logic       RX_HDLC_DATA_O,
  output logic       RX_HDLC_VALID_O,
  output logic       RX_ACQUISITION_O,
  output logic       RX_OUT_OF_FRAME_O,
  output logic       RX_LOSS_OF_FRAME_O,
  output logic       RX_LINE_CODE_VIOLATION_O
);

  // Gray code to binary for the event pointers
  function automatic logic [3:0] gray2bin(input logic [3:0] g);
    logic [3:0] b;
    b[3] = g[3];
    for (int i = 2; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction

  // ---------------- Reset synchronisers ----------------
  logic rst_meta_reg;     // System reset, first stage
  logic rst_n_reg;        // System reset used by the design
  logic lrst_meta_reg;    // Link reset, first stage
  logic lrst_n_reg;       // Link reset used by the link logic
  logic lclk;             // Recovered line clock

  assign lclk = RX_RECOVERED_LINE_CLOCK_I;

  // Release of the system reset
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // Release of the link reset on the line clock
  always_ff @(posedge lclk or negedge RST_B_I) begin
    if (!RST_B_I) begin
      lrst_meta_reg <= 1'b0;
      lrst_n_reg    <= 1'b0;
    end else begin
      lrst_meta_reg <= 1'b1;
      lrst_n_reg    <= lrst_meta_reg;
    end
  end

  // ---------------- Register file (system clock) ----------------
  logic [7:0]  io_ctrl_reg;      // Line control, writable bits only
  logic        dwell_sel_reg;    // Short out-of-frame dwell when set
  logic        reframe_tgl_reg;  // Flips on each reframe request
  logic [15:0] evt_cnt_reg;      // Cumulative violation count
  logic [15:0] sec_run_reg;      // Running one-second accumulation
  logic [15:0] sec_hold_reg;     // Last completed second
  logic [31:0] sec_tick_reg;     // One-second timebase
  logic [2:0]  stat_meta_reg;    // Framer status, first stage
  logic [2:0]  stat_sync_reg;    // Framer status {lof, oof, acq}
  logic        io_wr;            // Write to line control
  logic        evt_clr;          // Read of the event count low byte
  logic        sec_tick;         // End of a one-second interval
  logic [3:0]  ev_delta [2];     // New events since last cycle
  logic [15:0] lcv_add;          // Violations to add
  logic [15:0] sec_add;          // Second accumulator increment

  assign io_wr    = WR_STROBE_I & (ADDR_I == `E3RX_ADDR_IO_CTRL);
  assign evt_clr  = RD_STROBE_I & (ADDR_I == `E3RX_ADDR_EVT_LSB);
  assign sec_tick = sec_tick_reg == 32'(ONE_SECOND_CYCLES - 1);
  assign lcv_add  = {12'h000, ev_delta[0]};
  assign sec_add  = lcv_add + {12'h000, ev_delta[1]};

  // Writable control bits and reframe request
  always_ff @(posedge CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      io_ctrl_reg     <= `E3RX_IO_CTRL_RESET;
      dwell_sel_reg   <= 1'b0;
      reframe_tgl_reg <= 1'b0;
    end else if (WR_STROBE_I) begin
      if (io_wr) begin
        io_ctrl_reg <= WR_DATA_I & `E3RX_IO_CTRL_MASK;
        // Reframe bit acts once and reads back as zero
        if (WR_DATA_I[`E3RX_IO_REFRAME]) begin
          reframe_tgl_reg <= ~reframe_tgl_reg;
        end
      end
      if (ADDR_I == `E3RX_ADDR_RX_CFG) begin
        dwell_sel_reg <= WR_DATA_I[`E3RX_CFG_DWELL];
      end
    end
  end

  // Cumulative count, cleared by reading its low byte
  always_ff @(posedge CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      evt_cnt_reg <= 16'h0000;
    end else if (evt_clr) begin
      // Events of this cycle survive the clear
      evt_cnt_reg <= lcv_add; // R2
    end else begin
      evt_cnt_reg <= evt_cnt_reg + lcv_add; // R2
    end
  end

  // One-second timebase
  always_ff @(posedge CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sec_tick_reg <= 32'h0;
    end else if (sec_tick) begin
      sec_tick_reg <= 32'h0;
    end else begin
      sec_tick_reg <= sec_tick_reg + 32'h1;
    end
  end

  // Violations and zero runs accumulate per second
  always_ff @(posedge CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sec_run_reg  <= 16'h0000;
      sec_hold_reg <= 16'h0000;
    end else if (sec_tick) begin
      sec_hold_reg <= sec_run_reg;
      sec_run_reg  <= sec_add; // R3 R4
    end else begin
      sec_run_reg  <= sec_run_reg + sec_add; // R3 R4
    end
  end

  // Framer status into the system domain
  always_ff @(posedge CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      stat_meta_reg <= 3'h1;
      stat_sync_reg <= 3'h1;
    end else begin
      stat_meta_reg <= {RX_LOSS_OF_FRAME_O, RX_OUT_OF_FRAME_O, RX_ACQUISITION_O};
      stat_sync_reg <= stat_meta_reg;
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      RD_DATA_O <= 8'h00;
    end else if (RD_STROBE_I) begin
      unique case (ADDR_I)
        `E3RX_ADDR_IO_CTRL: RD_DATA_O <= io_ctrl_reg;
        `E3RX_ADDR_RX_CFG:  RD_DATA_O <= {dwell_sel_reg, stat_sync_reg[2],
                                          stat_sync_reg[1], stat_sync_reg[0],
                                          4'h0};
        `E3RX_ADDR_EVT_MSB: RD_DATA_O <= evt_cnt_reg[15:8];
        `E3RX_ADDR_EVT_LSB: RD_DATA_O <= evt_cnt_reg[7:0];
        `E3RX_ADDR_SEC_MSB: RD_DATA_O <= sec_hold_reg[15:8];
        `E3RX_ADDR_SEC_LSB: RD_DATA_O <= sec_hold_reg[7:0];
        default:            RD_DATA_O <= 8'h00;
      endcase
    end else begin
      RD_DATA_O <= 8'h00;
    end
  end

  // ---------------- Crossings into the link domain ----------------
  logic [3:0] ctrl_meta_reg;   // Control levels, first stage
  logic [3:0] ctrl_sync_reg;   // {dwell, ami, unipolar, invert}
  logic       rf_meta_reg;     // Reframe toggle, first stage
  logic       rf_sync_reg;     // Reframe toggle, synchronised
  logic       rf_prev_reg;     // Previous toggle for edge detect
  logic       reframe;         // One-cycle reframe request

  assign reframe = rf_sync_reg ^ rf_prev_reg;

  // Static control levels and reframe toggle
  always_ff @(posedge lclk or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      ctrl_meta_reg <= 4'h0;
      ctrl_sync_reg <= 4'h0;
      rf_meta_reg   <= 1'b0;
      rf_sync_reg   <= 1'b0;
      rf_prev_reg   <= 1'b0;
    end else begin
      ctrl_meta_reg <= {dwell_sel_reg, io_ctrl_reg[`E3RX_IO_ZSUP_SEL],
                        io_ctrl_reg[`E3RX_IO_UNIPOLAR], io_ctrl_reg[`E3RX_IO_RX_INV]};
      ctrl_sync_reg <= ctrl_meta_reg;
      rf_meta_reg   <= reframe_tgl_reg;
      rf_sync_reg   <= rf_meta_reg;
      rf_prev_reg   <= rf_sync_reg;
    end
  end

  // ---------------- Rail sampling ----------------
  logic fall_pos_reg;   // Rails caught on the falling edge
  logic fall_neg_reg;
  logic rise_pos_reg;   // Rails caught on the rising edge
  logic rise_neg_reg;
  logic line_pos_reg;   // Selected samples, rising-edge timed
  logic line_neg_reg;

  // Falling-edge capture
  always_ff @(negedge lclk or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      fall_pos_reg <= 1'b0;
      fall_neg_reg <= 1'b0;
    end else begin
      fall_pos_reg <= RX_RAIL_POSITIVE_I; // R6
      fall_neg_reg <= RX_RAIL_NEGATIVE_I; // R6
    end
  end

  // Rising-edge capture and edge selection
  always_ff @(posedge lclk or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      rise_pos_reg <= 1'b0;
      rise_neg_reg <= 1'b0;
      line_pos_reg <= 1'b0;
      line_neg_reg <= 1'b0;
    end else begin
      rise_pos_reg <= RX_RAIL_POSITIVE_I; // R5
      rise_neg_reg <= RX_RAIL_NEGATIVE_I; // R5
      line_pos_reg <= ctrl_sync_reg[0] ? fall_pos_reg : rise_pos_reg; // R5 R6
      line_neg_reg <= ctrl_sync_reg[0] ? fall_neg_reg : rise_neg_reg; // R5 R6
    end
  end

  // ---------------- Line decoder ----------------
  logic       dec_bit;    // Decoded binary stream
  logic       lcv_pulse;  // Line code violation
  logic       zrun_pulse; // Three-zero run seen
  logic [1:0] ev_pulse;   // {zero run, violation}

  assign RX_LINE_CODE_VIOLATION_O = lcv_pulse;
  assign ev_pulse = {zrun_pulse, lcv_pulse};

  e3rx_hdb3_decode u_decode (
    .clk_i      (lclk),
    .rst_n_i    (lrst_n_reg),
    .pos_i      (line_pos_reg),
    .neg_i      (line_neg_reg),
    .unipolar_i (ctrl_sync_reg[1]),
    .ami_i      (ctrl_sync_reg[2]),
    .bit_o      (dec_bit),
    .lcv_o      (lcv_pulse),
    .zero_run_o (zrun_pulse)
  );

  // Event counts cross as gray pointers, one lane per event kind
  for (genvar g = 0; g < 2; g++) begin : g_ev
    logic [3:0] bin_reg;    // Link-side event count
    logic [3:0] gray_reg;   // Its gray code
    logic [3:0] bin_next;   // Count after this cycle
    logic [3:0] meta_reg;   // System side, first stage
    logic [3:0] sync_reg;   // System side, second stage
    logic [3:0] seen_reg;   // Count already accounted

    assign bin_next    = bin_reg + {3'h0, ev_pulse[g]};
    assign ev_delta[g] = gray2bin(sync_reg) - seen_reg;

    // Link-side pointer
    always_ff @(posedge lclk or negedge lrst_n_reg) begin
      if (!lrst_n_reg) begin
        bin_reg  <= 4'h0;
        gray_reg <= 4'h0;
      end else begin
        bin_reg  <= bin_next;
        gray_reg <= bin_next ^ (bin_next >> 1);
      end
    end

    // System-side pointer
    always_ff @(posedge CLK_I or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
        meta_reg <= 4'h0;
        sync_reg <= 4'h0;
        seen_reg <= 4'h0;
      end else begin
        meta_reg <= gray_reg;
        sync_reg <= meta_reg;
        seen_reg <= gray2bin(sync_reg);
      end
    end
  end

  // ---------------- Frame acquisition and maintenance ----------------
  e3rx_state_e state_reg;    // Framer state
  e3rx_state_e state_next;
  logic [10:0] pos_reg;      // Bit position within the frame
  logic [9:0]  fas_sh_reg;   // Last ten decoded bits
  logic [1:0]  miss_reg;     // Consecutive missed words in frame
  logic [4:0]  dwell_reg;    // Frames spent out of frame
  logic [9:0]  win;          // Ten bits ending with the current one
  logic        fas_hit;      // Window holds the alignment word
  logic        at_check;     // Current bit closes the word slot
  logic        timing_ok;    // Frame timing is held
  logic [4:0]  dwell_lim;    // Allowed out-of-frame frames

  assign win       = {fas_sh_reg[8:0], dec_bit};
  assign fas_hit   = win == `E3RX_FAS_WORD; // R11
  assign at_check  = pos_reg == `E3RX_FAS_LAST_POS; // R13
  assign timing_ok = (state_reg == E3RX_IN_FRAME) || (state_reg == E3RX_OOF);
  assign dwell_lim = ctrl_sync_reg[3] ? `E3RX_DWELL_SHORT : `E3RX_DWELL_LONG;

  // Next framer state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      E3RX_SEARCH: begin
        if (fas_hit) begin
          state_next = E3RX_VERIFY; // R12
        end
      end
      E3RX_VERIFY: begin
        if (at_check) begin
          state_next = fas_hit ? E3RX_IN_FRAME : E3RX_SEARCH; // R14
        end
      end
      E3RX_IN_FRAME: begin
        if (at_check && !fas_hit && miss_reg == `E3RX_MISS_LIMIT) begin
          state_next = E3RX_OOF; // R15
        end
      end
      E3RX_OOF: begin
        if (at_check) begin
          if (fas_hit) begin
            state_next = E3RX_IN_FRAME;
          end else if (dwell_reg == dwell_lim - 5'h1) begin
            state_next = E3RX_LOF; // R16
          end
        end
      end
      E3RX_LOF: begin
        state_next = E3RX_SEARCH; // R17
      end
    endcase
    if (reframe) begin
      state_next = E3RX_SEARCH;
    end
  end

  // State register, starting in search
  always_ff @(posedge lclk or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      state_reg <= E3RX_SEARCH; // R10
    end else begin
      state_reg <= state_next; // R8 R9
    end
  end

  // Bit shifter and frame position
  always_ff @(posedge lclk or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      fas_sh_reg <= 10'h000;
      pos_reg    <= 11'h000;
    end else begin
      fas_sh_reg <= win;
      if (state_reg == E3RX_SEARCH && fas_hit) begin
        pos_reg <= `E3RX_FAS_LAST_POS + 11'h1; // R13
      end else if (state_reg == E3RX_LOF) begin
        pos_reg <= 11'h000; // R17
      end else if (pos_reg == `E3RX_FRAME_LAST) begin
        pos_reg <= 11'h000;
      end else begin
        pos_reg <= pos_reg + 11'h1;
      end
    end
  end

  // Missed-word and dwell counters
  always_ff @(posedge lclk or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      miss_reg  <= 2'h0;
      dwell_reg <= 5'h00;
    end else begin
      if (state_reg != E3RX_IN_FRAME || (at_check && fas_hit)) begin
        miss_reg <= 2'h0;
      end else if (at_check) begin
        miss_reg <= miss_reg + 2'h1; // R15
      end
      if (state_reg != E3RX_OOF) begin
        dwell_reg <= 5'h00;
      end else if (at_check) begin
        dwell_reg <= dwell_reg + 5'h1; // R16
      end
    end
  end

  // Mode and alarm outputs
  always_ff @(posedge lclk or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      RX_ACQUISITION_O   <= 1'b1;
      RX_OUT_OF_FRAME_O  <= 1'b0;
      RX_LOSS_OF_FRAME_O <= 1'b0;
    end else begin
      RX_ACQUISITION_O  <= state_next != E3RX_IN_FRAME; // R9
      RX_OUT_OF_FRAME_O <= state_next == E3RX_OOF;
      if (state_next == E3RX_LOF) begin
        RX_LOSS_OF_FRAME_O <= 1'b1;
      end else if (state_next == E3RX_IN_FRAME) begin
        RX_LOSS_OF_FRAME_O <= 1'b0;
      end
    end
  end

  // Decoded stream to the three consumers
  always_ff @(posedge lclk or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      RX_PAYLOAD_DATA_O   <= 1'b0;
      RX_PAYLOAD_VALID_O  <= 1'b0;
      RX_OVERHEAD_DATA_O  <= 1'b0;
      RX_OVERHEAD_VALID_O <= 1'b0;
      RX_HDLC_DATA_O      <= 1'b0;
      RX_HDLC_VALID_O     <= 1'b0;
    end else begin
      RX_PAYLOAD_DATA_O   <= dec_bit; // R7
      RX_OVERHEAD_DATA_O  <= dec_bit; // R7
      RX_HDLC_DATA_O      <= dec_bit; // R7
      RX_PAYLOAD_VALID_O  <= timing_ok && pos_reg >= `E3RX_OVH_BITS;
      RX_OVERHEAD_VALID_O <= timing_ok && pos_reg < `E3RX_OVH_BITS;
      RX_HDLC_VALID_O     <= timing_ok && pos_reg == `E3RX_NAT_POS;
    end
  end

endmodule

// File: common/e3rx_map.svh
// Functional notes
// (R1) Valid HDB3 violation decodes to four zeros
// (R2) Invalid violation flags and bumps event counter
// (R3) Each flagged violation also bumps second accumulator
// (R4) HDB3 three-zero run bumps second accumulator
// (R5) Invert bit clear samples rails on rising
// (R6) Invert bit set samples rails on falling
// (R7) Decoded stream feeds payload, overhead, HDLC consumers
// (R8) Framer always in acquisition or maintenance mode
// (R9) Search/verify/OUT_OF_FRAME/LOSS_OF_FRAME acquisition; in-frame maintenance
// (R10) Reset starts framer in search state
// (R11) Search every bit for ten-bit alignment word
// (R12) Candidate word moves search to verify
// (R13) Alignment word marks start of frame
// (R14) Verify one frame later; match in-frame else search
// (R15) Four missed words in-frame enters out-of-frame
// (R16) Dwell select limits out-of-frame to 24/8
// (R17) Loss of frame drops timing, returns search
// (R18) Single-rail mode reports no violations
`ifndef E3RX_MAP_SVH
`define E3RX_MAP_SVH

// Register offsets
`define E3RX_ADDR_IO_CTRL   8'h01
`define E3RX_ADDR_RX_CFG    8'h11
`define E3RX_ADDR_EVT_MSB   8'h50
`define E3RX_ADDR_EVT_LSB   8'h51
`define E3RX_ADDR_SEC_MSB   8'h6e
`define E3RX_ADDR_SEC_LSB   8'h6f

// Line control and receive config field positions
`define E3RX_IO_REFRAME     0
`define E3RX_IO_RX_INV      1
`define E3RX_IO_UNIPOLAR    3
`define E3RX_IO_ZSUP_SEL    4
`define E3RX_CFG_DWELL      7
`define E3RX_CFG_LOF        6
`define E3RX_CFG_OOF        5
`define E3RX_CFG_ACQ        4

// Reset values and writable masks
`define E3RX_IO_CTRL_RESET  8'ha0
`define E3RX_IO_CTRL_MASK   8'hbe

// Frame layout
`define E3RX_FAS_WORD       10'h3d0
`define E3RX_FRAME_LAST     11'h5ff
`define E3RX_FAS_LAST_POS   11'h009
`define E3RX_OVH_BITS       11'h00c
`define E3RX_NAT_POS        11'h00b
`define E3RX_MISS_LIMIT     2'h3
`define E3RX_DWELL_LONG     5'h18
`define E3RX_DWELL_SHORT    5'h08

// Timing
`define E3RX_CLK_PERIOD_NS  25
`define E3RX_ONE_SECOND_NS  1000000000
`define E3RX_ONE_SECOND_CYC (`E3RX_ONE_SECOND_NS / `E3RX_CLK_PERIOD_NS)

`endif

// File: common/e3rx_pkg.sv
package e3rx_pkg;

  // Framer acquisition and maintenance states
  typedef enum logic [2:0] {
    E3RX_SEARCH,
    E3RX_VERIFY,
    E3RX_IN_FRAME,
    E3RX_OOF,
    E3RX_LOF
  } e3rx_state_e;

  // Register data byte
  typedef logic [7:0] e3rx_byte_t;

endpackage

// File: hw/e3rx_hdb3_decode.sv
module e3rx_hdb3_decode (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pos_i,
  input  wire logic neg_i,
  input  wire logic unipolar_i,
  input  wire logic ami_i,
  output logic      bit_o,
  output logic      lcv_o,
  output logic      zero_run_o
);

  logic [2:0] mark_dly_reg;  // Last three symbols, newest in bit 0
  logic       last_neg_reg;  // Polarity of the last mark
  logic [1:0] zero_cnt_reg;  // Saturating line zero run length
  logic       is_mark;       // A pulse on either rail
  logic       both;          // Both rails at once, never legal
  logic       viol;          // Pulse repeats the last polarity
  logic       valid_sub;     // Violation closing 000V or B00V
  logic       hdb3_mode;     // Bipolar with zero substitution

  assign is_mark   = pos_i | neg_i;
  assign both      = pos_i & neg_i;
  assign viol      = is_mark & ~both & (neg_i == last_neg_reg);
  assign hdb3_mode = ~unipolar_i & ~ami_i;
  assign valid_sub = viol & hdb3_mode & ~mark_dly_reg[0] & ~mark_dly_reg[1];

  // Three-symbol delay so that a B pulse can still be erased
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mark_dly_reg <= 3'h0;
      bit_o        <= 1'b0;
    end else if (unipolar_i) begin
      mark_dly_reg <= {mark_dly_reg[1:0], pos_i};
      bit_o        <= mark_dly_reg[2];
    end else if (valid_sub) begin
      // Oldest symbol and the violation both become zeros
      mark_dly_reg <= 3'h0; // R1
      bit_o        <= 1'b0; // R1
    end else begin
      mark_dly_reg <= {mark_dly_reg[1:0], is_mark};
      bit_o        <= mark_dly_reg[2];
    end
  end

  // Polarity of the previous mark, violations included
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_neg_reg <= 1'b1;
    end else if (is_mark & ~both & ~unipolar_i) begin
      last_neg_reg <= neg_i;
    end
  end

  // Violation pulse, silent in single-rail mode
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lcv_o <= 1'b0;
    end else begin
      lcv_o <= ~unipolar_i & ((viol & ~valid_sub) | both); // R2 R18
    end
  end

  // One pulse per zero run reaching three symbols
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      zero_cnt_reg <= 2'h0;
      zero_run_o   <= 1'b0;
    end else if (!hdb3_mode || is_mark) begin
      zero_cnt_reg <= 2'h0;
      zero_run_o   <= 1'b0;
    end else begin
      if (zero_cnt_reg != 2'h3) begin
        zero_cnt_reg <= zero_cnt_reg + 2'h1;
      end
      zero_run_o <= (zero_cnt_reg == 2'h2); // R4
    end
  end

endmodule

// File: testbench/e3rx_top_properties.sv
module e3rx_checker
  import e3rx_pkg::*;
(
  input wire logic       CLK_I,
  input wire logic       RST_B_I,
  input wire logic       RX_RECOVERED_LINE_CLOCK_I,
  input wire logic       RD_STROBE_I,
  input wire e3rx_byte_t RD_DATA_O,
  input wire logic       RX_PAYLOAD_VALID_O,
  input wire logic       RX_OVERHEAD_VALID_O,
  input wire logic       RX_HDLC_VALID_O,
  input wire logic       RX_ACQUISITION_O,
  input wire logic       RX_OUT_OF_FRAME_O,
  input wire logic       RX_LOSS_OF_FRAME_O
);
  // Link domain by default
  default clocking @(posedge RX_RECOVERED_LINE_CLOCK_I); endclocking
  default disable iff (!RST_B_I);
  // Twelve overhead slots
  sequence ovh12_s;
    RX_OVERHEAD_VALID_O [*8] ##1 RX_OVERHEAD_VALID_O [*4];
  endsequence
  // HDLC slot is the twelfth
  sequence hdlc11_s;
    !RX_HDLC_VALID_O [*8] ##1 !RX_HDLC_VALID_O [*3] ##1 RX_HDLC_VALID_O;
  endsequence
  read_slot_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !$past(RD_STROBE_I) |-> RD_DATA_O == 8'h00) else $error("read data out of slot");
  oof_mode_a: assert property (RX_OUT_OF_FRAME_O |-> RX_ACQUISITION_O)
    else $error("out of frame outside acquisition");
  lof_mode_a: assert property (RX_LOSS_OF_FRAME_O |-> RX_ACQUISITION_O)
    else $error("loss of frame outside acquisition");
  sinks_apart_a: assert property (!(RX_PAYLOAD_VALID_O && RX_OVERHEAD_VALID_O))
    else $error("payload and overhead both valid");
  // Only frame wraps start a full head; lock lands mid-overhead
  frame_head_a: assert property (disable iff (!RST_B_I || RX_LOSS_OF_FRAME_O)
    $rose(RX_OVERHEAD_VALID_O) && $past(RX_PAYLOAD_VALID_O) |-> ovh12_s ##1 RX_PAYLOAD_VALID_O)
    else $error("bad frame head");
  hdlc_slot_a: assert property (disable iff (!RST_B_I || RX_LOSS_OF_FRAME_O)
    $rose(RX_OVERHEAD_VALID_O) && $past(RX_PAYLOAD_VALID_O) |-> hdlc11_s)
    else $error("bad hdlc slot");
  oof_entry_a: assert property ($rose(RX_OUT_OF_FRAME_O) |-> !$past(RX_ACQUISITION_O))
    else $error("out of frame not from in frame");
  lof_drop_a: assert property ($rose(RX_LOSS_OF_FRAME_O) |-> ##[0:2]
    !(RX_OUT_OF_FRAME_O || RX_PAYLOAD_VALID_O || RX_OVERHEAD_VALID_O))
    else $error("timing kept after loss");
endmodule

bind e3rx_top e3rx_checker u_chk (.CLK_I, .RST_B_I, .RX_RECOVERED_LINE_CLOCK_I,
  .RD_STROBE_I, .RD_DATA_O, .RX_PAYLOAD_VALID_O, .RX_OVERHEAD_VALID_O,
  .RX_HDLC_VALID_O, .RX_ACQUISITION_O, .RX_OUT_OF_FRAME_O, .RX_LOSS_OF_FRAME_O);

// File: testbench/e3rx_liu_model.sv
module e3rx_liu_model (
  input  wire logic inv_i,  // Falling edge sampling
  output logic      clk_o,  // Line clock, 64 ns
  output logic      pos_o,  // Positive rail
  output logic      neg_o   // Negative rail
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] sym_q[$];  // Pending symbols, pos high bit
  logic [1:0] sym;       // Symbol on the wire
  // Queue one symbol n times
  task automatic push(input logic [1:0] s, input int n);
    repeat (n) sym_q.push_back(s);
  endtask
  // Rails hold the symbol only around the sampling edge
  initial begin
    clk_o = 1'b0;
    {pos_o, neg_o} = 2'b00;
    forever begin
      sym = (sym_q.size() > 0) ? sym_q.pop_front() : 2'b00;
      #16 {pos_o, neg_o} = sym;
      #16 clk_o = ~inv_i;
      #16 {pos_o, neg_o} = ~sym;
      #16 clk_o = inv_i;
    end
  end
endmodule

// File: testbench/e3_rx_line_decode_frame_search_tb.sv
module e3_rx_line_decode_frame_search_tb import e3rx_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst_b, ws, rs, inv;       // Clock, reset, strobes, edge
  logic       acq, out_of_frame, loss_of_frame, line_code_violation, lclk, rp, rn; // Status and line
  logic [7:0] addr, wd;                      // Bus address, data
  e3rx_byte_t rdd, d;                        // Read data
  int         n_mismatch = 0, check_count = 0, n_lcv = 0, base;

  e3rx_top #(.ONE_SECOND_CYCLES(200)) u_e3rx_top (.CLK_I(clk), .RST_B_I(rst_b),
    .RX_RECOVERED_LINE_CLOCK_I(lclk), .RX_RAIL_POSITIVE_I(rp), .RX_RAIL_NEGATIVE_I(rn),
    .ADDR_I(addr), .WR_DATA_I(wd), .WR_STROBE_I(ws), .RD_STROBE_I(rs), .RD_DATA_O(rdd),
    .RX_PAYLOAD_DATA_O(), .RX_PAYLOAD_VALID_O(), .RX_OVERHEAD_DATA_O(),
    .RX_OVERHEAD_VALID_O(), .RX_HDLC_DATA_O(), .RX_HDLC_VALID_O(),
    .RX_ACQUISITION_O(acq), .RX_OUT_OF_FRAME_O(out_of_frame), .RX_LOSS_OF_FRAME_O(loss_of_frame),
    .RX_LINE_CODE_VIOLATION_O(line_code_violation));
  e3rx_liu_model u_e3rx_liu_model (.inv_i(inv), .clk_o(lclk), .pos_o(rp), .neg_o(rn));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Violation pulses seen at the port
  always @(posedge lclk) if (line_code_violation === 1'b1) n_lcv++;
  // Byte within inclusive range
  task automatic chk(input logic [7:0] got, lo, hi);
    check_count++;
    if ($isunknown(got) || got < lo || got > hi) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h..%h", $time, got, lo, hi);
    end
  endtask
  // One-cycle write
  task automatic wr(input logic [7:0] a, v);
    @(posedge clk);
    addr <= a;
    wd <= v;
    ws <= 1'b1;
    @(posedge clk);
    ws <= 1'b0;
  endtask
  // Read, data in the following cycle
  task automatic rc(input logic [7:0] a, lo, hi);
    @(posedge clk);
    addr <= a;
    rs <= 1'b1;
    @(posedge clk);
    rs <= 1'b0;
    @(negedge clk);
    chk(rdd, lo, hi);
  endtask
  task automatic lw(input int n);
    repeat (n) @(posedge lclk);
  endtask
  task automatic tx(input logic [1:0] s, input int n);
    u_e3rx_liu_model.push(s, n);
  endtask
  // Wait until the line queue empties
  task automatic drain;
    for (int k = 0; k < 9000 && u_e3rx_liu_model.sym_q.size() > 0; k++) @(posedge lclk);
    lw(12);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Cut a hang short
  initial begin
    #2500000;
    n_mismatch++;
    stop_test();
  end
  // Main sequence
  initial begin
    {ws, rs, inv, rst_b} = 4'h0;
    {addr, wd} = 16'h0000;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    chk({7'h00, acq}, 8'h01, 8'h01);
    rc(8'h01, 8'ha0, 8'ha0);
    rc(8'h00, 8'h00, 8'h00);
    wr(8'h50, 8'hff);
    rc(8'h50, 8'h00, 8'h00);
    wr(8'h01, 8'hff);
    rc(8'h01, 8'hbe, 8'hbe);
    $display("test registers done");
    // Both sampling edges; rails invert away from the chosen edge
    for (int e = 0; e < 2; e++) begin
      wr(8'h01, e ? 8'ha2 : 8'ha0);
      inv = e[0];
      lw(16);
      rc(8'h51, 8'h00, 8'hff);
      base = n_lcv;
      tx(2'b11, 5);
      drain();
      rc(8'h50, 8'h00, 8'h00);
      rc(8'h51, 8'h05, 8'h05);
      chk(8'(n_lcv - base), 8'h05, 8'h05);
    end
    // Legal 000V then B00V: no violation may be flagged
    base = n_lcv;
    tx(2'b10, 1);
    tx(2'b00, 3);
    tx(2'b10, 1);
    tx(2'b01, 1);
    tx(2'b00, 2);
    tx(2'b01, 1);
    drain();
    rc(8'h51, 8'h00, 8'h00);
    chk(8'(n_lcv - base), 8'h00, 8'h00);
    $display("test edges done");
    wr(8'h01, 8'haa);
    lw(16);
    rc(8'h51, 8'h00, 8'hff);
    base = n_lcv;
    tx(2'b11, 5);
    drain();
    rc(8'h51, 8'h00, 8'h00);
    chk(8'(n_lcv - base), 8'h00, 8'h00);
    $display("test single rail done");
    // 78.125 symbols per 5 us second
    wr(8'h01, 8'ha2);
    tx(2'b11, 400);
    repeat (600) @(posedge clk);
    rc(8'h6e, 8'h00, 8'h00);
    rc(8'h6f, 8'd78, 8'd79);
    drain();
    repeat (50) begin
      tx(2'b00, 3);
      tx(2'b10, 1);
      tx(2'b00, 3);
      tx(2'b01, 1);
    end
    repeat (600) @(posedge clk);
    rc(8'h6f, 8'd19, 8'd20);
    drain();
    $display("test accumulation done");
    // Three aligned frames, then silence
    wr(8'h01, 8'haa);
    wr(8'h11, 8'h80);
    repeat (3) begin
      tx(2'b10, 4);
      tx(2'b00, 1);
      tx(2'b10, 1);
      tx(2'b00, 1530);
    end
    drain();
    chk({7'h00, acq}, 8'h00, 8'h00);
    rc(8'h11, 8'h80, 8'h80);
    lw(1536 * 4 + 768);
    chk({5'h00, acq, out_of_frame, loss_of_frame}, 8'h06, 8'h06);
    lw(1536 * 10);
    chk({5'h00, acq, out_of_frame, loss_of_frame}, 8'h05, 8'h05);
    rc(8'h11, 8'hd0, 8'hd0);
    $display("test framing done");
    stop_test();
  end
endmodule
